// ==== core/isd_engine.sv ====
// interrupt split descriptor engine with its register window
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`include "isd_defines.svh"

module isd_engine (
  input  wire logic            ref_clk_in,
  input  wire logic            reset_in,
  input  wire logic            hsel_in,
  input  wire logic [31:0]     haddr_in,
  input  wire logic [1:0]      htrans_in,
  input  wire logic            hwrite_in,
  input  wire logic [2:0]      hsize_in,
  input  wire isd_pkg::isd_word_t hwdata_in,
  input  wire logic            hready_in,
  output      isd_pkg::isd_word_t hrdata_out,
  output      logic            hreadyout_out,
  output      logic            hresp_out,
  input  wire logic            uframe_tick_in,
  input  wire logic [4:0]      frame_num_in,
  input  wire logic [2:0]      uframe_idx_in,
  output      logic            issue_out,
  output      logic            issue_split_out,
  output      logic            issue_complete_out,
  output      logic            issue_toggle_out,
  output      logic [6:0]      issue_hub_out,
  output      logic [6:0]      issue_port_out,
  output      logic [1:0]      issue_speed_out,
  output      logic [15:0]     issue_buf_out,
  input  wire logic            done_in,
  input  wire logic [2:0]      done_status_in,
  input  wire logic            done_stall_in,
  input  wire logic [11:0]     done_bytes_in
);
  import isd_pkg::*;

  isd_word_t  desc_r   [`ISD_NWORDS];
  isd_word_t  desc_nxt [`ISD_NWORDS];
  isd_state_t state_r;
  isd_state_t state_nxt;
  logic [2:0] slot_r;
  logic       wr_pend_r;
  logic       wr_arr_r;
  logic [2:0] wr_idx_r;
  isd_word_t  hw_q0lo;
  isd_word_t  hw_q2hi;
  isd_word_t  hw_q3lo;
  logic [7:0] stat_err;
  logic [7:0] stat_bab;
  isd_sched_if sif ();

  ////////////////////////////////////////////////////////////////////////
  // bus decode, address phase
  wire        addr_go  = hsel_in & hready_in & htrans_in[1];
  wire        rd_go    = addr_go & ~hwrite_in;
  wire        wr_go    = addr_go & hwrite_in;
  wire        addr_hi0 = (haddr_in[31:8] == `ISD_HADDR_HI0);
  wire        arr_hit  = addr_hi0 & (haddr_in[7:5] == `ISD_OFS_ARR_PAGE)
                         & (haddr_in[1:0] == 2'h0);
  wire        eng_hit  = addr_hi0 & (haddr_in[7:0] == `ISD_OFS_ENGINE);
  wire [2:0]  rd_idx   = haddr_in[4:2];
  wire        sw_wr    = wr_pend_r & wr_arr_r;
  // a read right behind a write to the same word sees the new data
  wire        rd_fwd   = sw_wr & arr_hit & (wr_idx_r == rd_idx);

  ////////////////////////////////////////////////////////////////////////
  // descriptor fields
  wire        pending     = desc_r[`ISD_WI_Q0LO][`ISD_V_BIT];
  wire [4:0]  rate        = desc_r[`ISD_WI_Q1LO][`ISD_RATE_LSB +: 5];
  wire [15:0] buf_base    = desc_r[`ISD_WI_Q1LO][`ISD_BUF_LSB +: 16];
  wire        route_split = desc_r[`ISD_WI_Q1HI][`ISD_ROUTE_BIT];
  wire [1:0]  speed_class = desc_r[`ISD_WI_Q1HI][`ISD_SPEED_LSB +: 2];
  wire [6:0]  port_id     = desc_r[`ISD_WI_Q1HI][`ISD_PORT_LSB +: 7];
  wire [6:0]  hub_id      = desc_r[`ISD_WI_Q1HI][`ISD_HUB_LSB +: 7];
  wire        active      = desc_r[`ISD_WI_Q2HI][`ISD_A_BIT];
  wire        halt        = desc_r[`ISD_WI_Q2HI][`ISD_H_BIT];
  wire        babble      = desc_r[`ISD_WI_Q2HI][`ISD_B_BIT];
  wire        xact_err    = desc_r[`ISD_WI_Q2HI][`ISD_X_BIT];
  wire        split_phase = desc_r[`ISD_WI_Q2HI][`ISD_SC_BIT];
  wire        toggle_bit  = desc_r[`ISD_WI_Q2HI][`ISD_DT_BIT];
  wire [1:0]  cerr        = desc_r[`ISD_WI_Q2HI][`ISD_CERR_LSB +: 2];
  wire [11:0] moved_byte_count = desc_r[`ISD_WI_Q2HI][`ISD_BYTES_LSB +: 12];
  wire [7:0]  start_split_slot_mask = desc_r[`ISD_WI_Q3LO][`ISD_SLOT_LSB +: 8];
  wire        slot_bit_now = start_split_slot_mask[uframe_idx_in];

  ////////////////////////////////////////////////////////////////////////
  // engine status word, read only
  wire isd_word_t eng_word = {25'h0, active, pending, slot_r, state_r};
  wire isd_word_t rd_word  = rd_fwd  ? hwdata_in :
                             arr_hit ? desc_r[rd_idx] :
                             eng_hit ? eng_word : `ISD_ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////
  // scheduler hookup; only a descriptor marked pending and active runs
  assign sif.clk        = ref_clk_in;
  assign sif.rst        = reset_in;
  assign sif.tick       = uframe_tick_in;
  assign sif.frame_num  = frame_num_in;
  assign sif.uframe_idx = uframe_idx_in;
  assign sif.rate       = rate;
  assign sif.slots      = start_split_slot_mask;
  assign sif.armed      = pending & active & (state_r == ISD_S_IDLE);

  isd_sched u_sched (
    .sif (sif)
  );

  ////////////////////////////////////////////////////////////////////////
  // result classification
  wire       done_take  = (state_r == ISD_S_WAIT) & done_in;
  wire       fail_now   = done_status_in[`ISD_RES_ERR]
                          | done_status_in[`ISD_RES_BAB];
  wire       ok_now     = ~fail_now & ~done_stall_in;
  wire       retry_now  = fail_now & ~done_stall_in
                          & (cerr != `ISD_CERR_NONE);
  wire       fatal_now  = done_stall_in
                          | (fail_now & (cerr == `ISD_CERR_NONE));
  // a slot is spent after its high speed or complete split phase
  wire       step_done  = ok_now & (~route_split | split_phase);
  wire [7:0] clr_mask   = 8'(`ISD_ONE8 << slot_r);
  wire [7:0] slots_left = start_split_slot_mask & ~clr_mask;
  wire       finished   = fatal_now | (step_done & (slots_left == 8'h00));
  // an engine halt survives a software write to its word in that cycle
  wire       halt_evt   = done_take & done_stall_in;
  wire isd_word_t halt_keep = isd_word_t'(halt_evt) << `ISD_H_BIT;

  // per microframe result bits feeding the summary flags
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_stat
      assign stat_err[g] = hw_q3lo[`ISD_STAT_LSB + `ISD_STAT_W * g
                                   + `ISD_RES_ERR];
      assign stat_bab[g] = hw_q3lo[`ISD_STAT_LSB + `ISD_STAT_W * g
                                   + `ISD_RES_BAB];
    end
  endgenerate

  // slot mask and per microframe results
  always_comb begin
    hw_q3lo = desc_r[`ISD_WI_Q3LO];
    if (done_take) begin
      hw_q3lo[`ISD_STAT_LSB + `ISD_STAT_W * slot_r +: 3] = done_status_in;
      if (step_done | fatal_now) begin
        hw_q3lo[`ISD_SLOT_LSB +: 8] = slots_left;
      end
    end
  end

  // flags, toggle, retry counter and byte count
  always_comb begin
    hw_q2hi = desc_r[`ISD_WI_Q2HI];
    if (done_take) begin
      hw_q2hi[`ISD_BYTES_LSB +: 12] = done_bytes_in;
      if (ok_now) begin
        hw_q2hi[`ISD_DT_BIT] = ~toggle_bit;
      end
      if (ok_now & route_split) begin
        hw_q2hi[`ISD_SC_BIT] = ~split_phase;
      end
      if (retry_now) begin
        hw_q2hi[`ISD_CERR_LSB +: 2] = cerr - `ISD_CERR_STEP;
      end
      if (done_stall_in) begin
        hw_q2hi[`ISD_H_BIT] = 1'b1;
      end
      if (finished) begin
        hw_q2hi[`ISD_A_BIT] = 1'b0;
      end
      hw_q2hi[`ISD_B_BIT] = |stat_bab;
      hw_q2hi[`ISD_X_BIT] = |stat_err;
    end
  end

  // pending bit drops once the descriptor is spent or fails fatally
  always_comb begin
    hw_q0lo = desc_r[`ISD_WI_Q0LO];
    if (done_take & finished) begin
      hw_q0lo[`ISD_V_BIT] = 1'b0;
    end
  end

  // software write wins over the engine for the word it hits, except an engine halt set in that cycle
  generate
    for (g = 0; g < `ISD_NWORDS; g++) begin : g_word
      assign desc_nxt[g] =
        (sw_wr && wr_idx_r == 3'(g)) ? hwdata_in |
          ((3'(g) == `ISD_WI_Q2HI) ? halt_keep : `ISD_ZERO_WORD) :
        (3'(g) == `ISD_WI_Q0LO)      ? hw_q0lo :
        (3'(g) == `ISD_WI_Q2HI)      ? hw_q2hi :
        (3'(g) == `ISD_WI_Q3LO)      ? hw_q3lo : desc_r[g];
    end
  endgenerate

  // state step: one transaction in flight at a time
  assign state_nxt = (state_r == ISD_S_IDLE && sif.fire) ? ISD_S_WAIT :
                     done_take ? ISD_S_IDLE : state_r;

  ////////////////////////////////////////////////////////////////////////
  // descriptor storage
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < `ISD_NWORDS; i++) begin
      desc_r[i] <= reset_in ? `ISD_WORD_RESET : desc_nxt[i];
    end
  end

  // bus slave: zero wait, read data registered at the address phase
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wr_pend_r     <= 1'b0;
      wr_arr_r      <= 1'b0;
      wr_idx_r      <= 3'h0;
      hrdata_out    <= `ISD_ZERO_WORD;
      hreadyout_out <= 1'b1;
      hresp_out     <= `ISD_RESP_OKAY;
    end else begin
      wr_pend_r     <= wr_go;
      wr_arr_r      <= arr_hit;
      wr_idx_r      <= rd_idx;
      hrdata_out    <= rd_go ? rd_word : `ISD_ZERO_WORD;
      hreadyout_out <= 1'b1;
      hresp_out     <= `ISD_RESP_OKAY;
    end
  end

  // engine state and the registered transaction request
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_r            <= ISD_S_IDLE;
      slot_r             <= 3'h0;
      issue_out          <= 1'b0;
      issue_split_out    <= 1'b0;
      issue_complete_out <= 1'b0;
      issue_toggle_out   <= 1'b0;
      issue_hub_out      <= 7'h00;
      issue_port_out     <= 7'h00;
      issue_speed_out    <= `ISD_SPEED_NONE;
      issue_buf_out      <= 16'h0000;
    end else begin
      state_r   <= state_nxt;
      issue_out <= (state_r == ISD_S_IDLE) & sif.fire;
      if ((state_r == ISD_S_IDLE) && sif.fire) begin
        slot_r             <= sif.slot;
        issue_split_out    <= route_split;
        issue_complete_out <= split_phase;
        issue_toggle_out   <= toggle_bit;
        issue_hub_out      <= hub_id;
        issue_port_out     <= port_id;
        issue_speed_out    <= route_split ? speed_class
                                          : `ISD_SPEED_NONE;
        issue_buf_out      <= buf_base;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_take_ok;
    done_take && ok_now && !sw_wr;
  endsequence
  sequence s_take_fatal;
    done_take && fatal_now && !sw_wr;
  endsequence

  slot_clear_a: assert property (
    s_take_ok ##0 step_done |=> !start_split_slot_mask[$past(slot_r)])
    else $error("spent slot bit not cleared");
  issue_gate_a: assert property (
    issue_out |-> $past(slot_bit_now) ##1 state_r == ISD_S_WAIT)
    else $error("issue without slot bit or wait");
  active_clear_a: assert property (
    s_take_fatal |=> !active && !pending)
    else $error("fatal result left descriptor live");
  halt_set_a: assert property (
    done_take && done_stall_in && !sw_wr |=> halt)
    else $error("stall did not set halt");
  summary_flags_a: assert property (
    done_take && !sw_wr |=> babble == |stat_bab && xact_err == |stat_err)
    else $error("summary flags disagree with results");
  phase_flip_a: assert property (
    s_take_ok ##0 route_split |=> split_phase != $past(split_phase))
    else $error("split phase not advanced");
  toggle_wb_a: assert property (
    s_take_ok |=> toggle_bit != $past(toggle_bit))
    else $error("toggle not written back");
  retry_dec_a: assert property (
    done_take && retry_now && !sw_wr |=> cerr == $past(cerr) - 2'h1)
    else $error("retry counter not decremented");
  byte_count_a: assert property (
    done_take && !sw_wr |=> moved_byte_count == $past(done_bytes_in))
    else $error("byte count not written");
  route_fields_a: assert property (
    issue_out |-> issue_hub_out == $past(hub_id)
      && issue_port_out == $past(port_id)
      && (issue_split_out || issue_speed_out == 2'h0))
    else $error("routing fields wrong on issue");
endmodule

// ==== core/isd_defines.svh ====
// constants for the interrupt split descriptor engine
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH

// descriptor storage: eight words, each quad word as low then high word
`define ISD_NWORDS       8
`define ISD_WORD_RESET   32'h0000_0000
`define ISD_ZERO_WORD    32'h0000_0000
`define ISD_WI_Q0LO      3'h0
`define ISD_WI_Q1LO      3'h2
`define ISD_WI_Q1HI      3'h3
`define ISD_WI_Q2HI      3'h5
`define ISD_WI_Q3LO      3'h6

// byte addresses on the register bus
`define ISD_OFS_ARR_PAGE 3'h0
`define ISD_OFS_ENGINE   8'h20
`define ISD_HADDR_HI0    24'h00_0000

// quad word 0, low word
`define ISD_V_BIT        0
// quad word 1, low word
`define ISD_RATE_LSB     3
`define ISD_BUF_LSB      8
// quad word 1, high word
`define ISD_ROUTE_BIT    14
`define ISD_SPEED_LSB    16
`define ISD_PORT_LSB     18
`define ISD_HUB_LSB      25
// quad word 2, high word
`define ISD_BYTES_LSB    0
`define ISD_CERR_LSB     23
`define ISD_DT_BIT       25
`define ISD_SC_BIT       27
`define ISD_X_BIT        28
`define ISD_B_BIT        29
`define ISD_H_BIT        30
`define ISD_A_BIT        31
// quad word 3, low word
`define ISD_SLOT_LSB     0
`define ISD_STAT_LSB     8
`define ISD_STAT_W       3
// bits of one microframe result
`define ISD_RES_ERR      0
`define ISD_RES_BAB      1

// misc values
`define ISD_ONE8         8'h01
`define ISD_CERR_NONE    2'h0
`define ISD_CERR_STEP    2'h1
`define ISD_SPEED_NONE   2'h0
`define ISD_RESP_OKAY    1'h0

`endif

// ==== core/isd_pkg.sv ====
// types shared by the descriptor engine modules
package isd_pkg;
  typedef logic [31:0] isd_word_t;
  // idle -> wait along one gray step
  typedef enum logic [1:0] {
    ISD_S_IDLE = 2'h0,
    ISD_S_WAIT = 2'h1
  } isd_state_t;
endpackage

// ==== core/isd_sched_if.sv ====
// carrier between the engine and its microframe scheduler
interface isd_sched_if;
  logic       clk;
  logic       rst;
  logic       tick;
  logic [4:0] frame_num;
  logic [2:0] uframe_idx;
  logic [4:0] rate;
  logic [7:0] slots;
  logic       armed;
  logic       fire;
  logic [2:0] slot;
  modport eng (output clk, rst, tick, frame_num, uframe_idx, rate, slots,
               output armed, input fire, slot);
  modport sch (input clk, rst, tick, frame_num, uframe_idx, rate, slots,
               input armed, output fire, slot);
endinterface

// ==== core/isd_sched.sv ====
// decides in which microframe the descriptor is executed
module isd_sched (
  isd_sched_if.sch sif
);
  import isd_pkg::*;

  logic [4:0] smear1;
  logic [4:0] smear2;
  logic [4:0] rate_mask;
  logic       frame_hit;
  logic       slot_hit;

  // highest set bit of the rate field sets the period, the field the phase
  assign smear1    = sif.rate | (sif.rate >> 1);
  assign smear2    = smear1 | (smear1 >> 2);
  assign rate_mask = smear2 | (smear2 >> 4);
  // a zero field matches every frame, i.e. once each millisecond
  assign frame_hit = ((sif.frame_num & rate_mask) == sif.rate);
  assign slot_hit  = sif.slots[sif.uframe_idx];
  assign sif.fire  = sif.tick & sif.armed & frame_hit & slot_hit;
  assign sif.slot  = sif.uframe_idx;

  ////////////////////////////////////////////////////////////////////////
  // checks
  every_ms_a: assert property (
    @(posedge sif.clk) disable iff (sif.rst)
    (sif.tick && sif.armed && sif.rate == 5'h00 && slot_hit) |-> sif.fire)
    else $error("rate zero microframe not executed");
endmodule

// ==== dv/isd_tt_model.sv ====
// hub translator model: answers each issued transaction after a delay
module isd_tt_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        issue_in,
  input  wire logic [1:0]  dly_in,
  input  wire logic [2:0]  stat_in,
  input  wire logic        stall_in,
  input  wire logic [11:0] bytes_in,
  output      logic        done_out,
  output      logic [2:0]  stat_out,
  output      logic        stall_out,
  output      logic [11:0] bytes_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       busy_r;
  logic [1:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////
  // outside the result pulse the lines show junk, never the last value
  assign stat_out  = done_out ? stat_in : ~stat_in;
  assign stall_out = done_out ? stall_in : ~stall_in;
  assign bytes_out = done_out ? bytes_in : ~bytes_in;
  // one result per issue, after dly_in extra cycles
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_r   <= 1'b0;
      cnt_r    <= 2'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (issue_in) begin
        busy_r <= 1'b1;
        cnt_r  <= dly_in;
      end else if (busy_r && cnt_r == 2'h0) begin
        busy_r   <= 1'b0;
        done_out <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// ==== dv/isd_engine_tb.sv ====
// self-checking bench for the descriptor engine
module isd_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import isd_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        tick = 1'b0, hready, hresp, iss, isplit, icomp, itog;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0, ispd, mdly = 2'h0;
  logic [2:0]  hsize = 3'h2, uidx = 3'h0, dstat, mstat = 3'h0;
  logic [4:0]  fnum = 5'h0;
  logic [6:0]  ihub, iport;
  logic [15:0] ibuf;
  logic        done, dstall, mstall = 1'b0;
  logic [11:0] dbytes, mbytes = 12'h0;
  isd_word_t   hwdata = 32'h0, hrdata, rv;
  logic [31:0] q0, q1l, q1h, q2h, q3;
  int          num_errors = 0;
  int          compares = 0;
  integer      seed = 32'hFCD3;
  ////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  isd_engine u_dut (.ref_clk_in(clk), .reset_in(rst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .uframe_tick_in(tick), .frame_num_in(fnum), .uframe_idx_in(uidx),
    .issue_out(iss), .issue_split_out(isplit),
    .issue_complete_out(icomp), .issue_toggle_out(itog),
    .issue_hub_out(ihub), .issue_port_out(iport),
    .issue_speed_out(ispd), .issue_buf_out(ibuf), .done_in(done),
    .done_status_in(dstat), .done_stall_in(dstall),
    .done_bytes_in(dbytes));
  isd_tt_model u_tt (.clk_in(clk), .rst_in(rst), .issue_in(iss),
    .dly_in(mdly), .stat_in(mstat), .stall_in(mstall),
    .bytes_in(mbytes), .done_out(done), .stat_out(dstat),
    .stall_out(dstall), .bytes_out(dbytes));
  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output isd_word_t r);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // descriptor after one result, from the engine's update rules
  task automatic upd(input logic [2:0] s);
    logic       ok, fail, spent;
    logic [7:0] e, b;
    q3[8+3*s +: 3] = mstat;
    q2h[11:0] = mbytes;
    for (int i = 0; i < 8; i++) begin
      e[i] = q3[8+3*i];
      b[i] = q3[9+3*i];
    end
    q2h[28] = |e;
    q2h[29] = |b;
    ok = !mstat[0] && !mstat[1] && !mstall;
    fail = mstat[0] | mstat[1];
    spent = 1'b0;
    if (ok) begin
      spent = !q1h[14] || q2h[27];
      q2h[25] = !q2h[25];
      if (q1h[14]) q2h[27] = !q2h[27];
    end else if (fail && !mstall && q2h[24:23] != 2'h0) begin
      q2h[24:23] = q2h[24:23] - 2'h1;
    end else begin
      spent = 1'b1;
      if (mstall) q2h[30] = 1'b1;
      q2h[31] = 1'b0;
      q0[0] = 1'b0;
    end
    if (spent) q3[s] = 1'b0;
    if (spent && q3[7:0] == 8'h0) begin
      q2h[31] = 1'b0;
      q0[0] = 1'b0;
    end
  endtask
  // random descriptor, one microframe tick, result and read-back
  task automatic one_round(input logic every_ms);
    logic [31:0] w;
    logic [4:0]  f, m;
    logic        fire;
    w = $random(seed);
    q0 = {31'h0, w[0] | w[1]};
    f = every_ms ? 5'h0 : w[6:2];
    m = f | (f >> 1) | (f >> 2) | (f >> 3) | (f >> 4);
    q1l = $random(seed) & 32'h00FF_FFF8;
    q1l[7:3] = f;
    q1h = $random(seed) & 32'hFFFF_4000;
    q2h = $random(seed) & 32'hFB80_0FFF;
    q2h[31] = q0[0];
    q3 = $random(seed);
    uidx <= w[11:9];
    if (w[12] | w[13]) q3[w[11:9]] = 1'b1;
    if (w[27]) q3[7:4] = 4'h0;
    fnum <= w[14] ? (f | (w[19:15] & ~m)) : w[19:15];
    mstat <= 3'(4'h1 << w[21:20]);
    mstall <= w[22] & w[23] & w[24];
    mbytes <= w[31:20];
    mdly <= w[26:25];
    bus(1'b1, 32'h08, q1l, rv);
    bus(1'b1, 32'h0C, q1h, rv);
    bus(1'b1, 32'h14, q2h, rv);
    bus(1'b1, 32'h18, q3, rv);
    bus(1'b1, 32'h00, q0, rv);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
    fire = q0[0] & q2h[31] & q3[uidx] & ((fnum & m) == f);
    chk("issue", 32'(iss), 32'(fire));
    if (fire) begin
      chk("split", 32'(isplit), 32'(q1h[14]));
      chk("phase", 32'(icomp), 32'(q2h[27]));
      chk("toggle", 32'(itog), 32'(q2h[25]));
      chk("hub", 32'(ihub), 32'(q1h[31:25]));
      chk("port", 32'(iport), 32'(q1h[24:18]));
      chk("speed", 32'(ispd), q1h[14] ? 32'(q1h[17:16]) : 0);
      chk("buf", 32'(ibuf), 32'(q1l[23:8]));
      bus(1'b0, 32'h20, 32'h0, rv);
      chk("engine", rv, 32'h61 | (32'(uidx) << 2));
    end
    repeat (8) @(posedge clk);
    if (fire) upd(uidx);
    bus(1'b0, 32'h14, 32'h0, rv);
    chk("quad2_hi", rv, q2h);
    bus(1'b0, 32'h18, 32'h0, rv);
    chk("quad3_lo", rv, q3);
    bus(1'b0, 32'h00, 32'h0, rv);
    chk("pending", rv, q0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task test_done;
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well beyond the expected run time
  initial begin
    #1000000;
    num_errors++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 40; a += 4) begin
      bus(1'b0, 32'(a), 32'h0, rv);
      chk("reset_word", rv, 32'h0);
    end
    chk("resp", 32'(hresp), 32'h0);
    chk("ready", 32'(hready), 32'h1);
    bus(1'b1, 32'h24, 32'hFFFF_FFFF, rv);
    bus(1'b0, 32'h24, 32'h0, rv);
    chk("unmapped", rv, 32'h0);
    q0 = $random(seed);
    bus(1'b1, 32'h04, q0, rv);
    bus(1'b0, 32'h04, 32'h0, rv);
    chk("free_word", rv, q0);
    for (int n = 0; n < 300; n++) one_round(n % 4 == 0);
    test_done;
  end
endmodule
